// ==== rtl/dmux_top.sv ====
// DRAM address multiplexer with refresh counter and address transceiver.
// Assumes all control and bus inputs are asynchronous pins; the bench
// resolves the two-way buses from the output enables.
`timescale 1ns/1ps
`include "dmux_params.svh"

module dmux_top #(
  parameter int MA_W  = `DMUX_MA_W,
  parameter int SYS_W = `DMUX_SYS_W
) (
  // Clock, reset, enable
  input  wire logic               CLK_IN,
  input  wire logic               NRST_IN,
  input  wire logic               CE_IN,
  // CPU side
  input  wire logic [SYS_W:1]     CPU_ADDR_IN,
  input  wire logic               ALE_IN,
  // Refresh and mux control
  input  wire logic               REFRESH_REQ_IN,
  input  wire logic               REFRESH_PERMIT_IN,
  input  wire logic               ADDR_SOURCE_SELECT_IN,
  input  wire logic               COLUMN_SELECT_IN,
  input  wire logic               COUNTER_CLEAR_IN,
  // Transceiver control
  input  wire logic               CPU_HOLD_ACK_IN,
  input  wire logic               DMA_ACTIVE_IN,
  // Memory address
  output logic      [MA_W-1:0]    MEM_ADDR_OUT,
  output logic                    MEM_ADDR_OE_OUT,
  output logic                    REFRESH_ACTIVE_OUT,
  output logic                    REFRESH_ADDR_LSB_OUT,
  // Expansion address bus
  input  wire logic [SYS_W:1]     EXPANSION_ADDR_BUS_IN,
  output logic      [SYS_W:1]     EXPANSION_ADDR_BUS_OUT,
  output logic                    EXPANSION_ADDR_BUS_OE_OUT,
  // Peripheral address bus
  input  wire logic [SYS_W:1]     PERIPHERAL_ADDR_BUS_IN,
  output logic      [SYS_W:1]     PERIPHERAL_ADDR_BUS_OUT,
  output logic                    PERIPHERAL_ADDR_BUS_OE_OUT
);

  localparam int SW = `DMUX_CTL_W + 3 * SYS_W;

  // Synchroniser stages and filtered values
  logic [SW-1:0]        s1, s2, s3, filt;
  logic [SW-1:0]        next_filt;
  logic [SW-1:0]        raw;

  // Core state
  dmux_pkg::dmux_state_t state, next_state;
  logic [MA_W-1:0]      cnt, next_cnt;
  logic [SYS_W:1]       latch_addr, next_latch_addr;
  logic [MA_W-1:0]      ma, next_ma;
  logic                 ma_oe, next_ma_oe;
  logic [SYS_W:1]       sa_out, next_sa_out;
  logic                 sa_oe, next_sa_oe;
  logic [SYS_W:1]       xa_out, next_xa_out;
  logic                 xa_oe, next_xa_oe;

  // Filtered control levels
  logic                 ale, req, permit, src_sel, col_sel, clr, hold, dma;
  logic [SYS_W:1]       cpu_a, sa_in, xa_in;

  // Pin vector entering the synchroniser
  assign raw = {ALE_IN, REFRESH_REQ_IN, REFRESH_PERMIT_IN,
                ADDR_SOURCE_SELECT_IN, COLUMN_SELECT_IN, COUNTER_CLEAR_IN,
                CPU_HOLD_ACK_IN, DMA_ACTIVE_IN, CPU_ADDR_IN,
                EXPANSION_ADDR_BUS_IN, PERIPHERAL_ADDR_BUS_IN};
  assign {ale, req, permit, src_sel, col_sel, clr, hold, dma,
          cpu_a, sa_in, xa_in} = filt;

  // Filter takes a bit once stages two and three agree
  always_comb begin
    next_filt = (s2 & s3) | (filt & (s2 | s3));
  end

  // Three-stage synchroniser per pin
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      filt <= '0;
    end else if (CE_IN) begin
      s1   <= raw;
      s2   <= s1;
      s3   <= s2;
      filt <= next_filt;
    end
  end

  // Next values of the refresh, mux and transceiver logic
  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_latch_addr = latch_addr;
    if (ale)
      next_latch_addr = cpu_a;
    unique case (state)
      dmux_pkg::DMUX_IDLE: begin
        if (req && permit)
          next_state = dmux_pkg::DMUX_REFRESH;
      end
      dmux_pkg::DMUX_REFRESH: begin
        if (!req) begin
          next_state = dmux_pkg::DMUX_IDLE;
          next_cnt   = MA_W'(cnt + 1'b1);
        end
      end
    endcase
    if (clr) begin
      next_state = dmux_pkg::DMUX_IDLE;
      next_cnt   = `DMUX_CNT_RESET;
    end
    if (next_state == dmux_pkg::DMUX_REFRESH || !src_sel)
      next_ma = next_cnt;
    else if (col_sel)
      next_ma = next_latch_addr[SYS_W:MA_W+1];
    else
      next_ma = next_latch_addr[MA_W:1];
    next_ma_oe = !clr;
    next_sa_out = next_latch_addr;
    next_sa_oe  = !hold;
    next_xa_out = next_latch_addr;
    next_xa_oe  = !hold;
    if (dma) begin
      next_xa_out = sa_in;
      next_xa_oe  = 1'b1;
      next_sa_out = xa_in;
    end
  end

  // Core registers
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state      <= dmux_pkg::DMUX_IDLE;
      cnt        <= `DMUX_CNT_RESET;
      latch_addr <= `DMUX_ADDR_RESET;
      ma         <= '0;
      ma_oe      <= 1'b0;
      sa_out     <= `DMUX_ADDR_RESET;
      sa_oe      <= 1'b0;
      xa_out     <= `DMUX_ADDR_RESET;
      xa_oe      <= 1'b0;
    end else if (CE_IN) begin
      state      <= next_state;
      cnt        <= next_cnt;
      latch_addr <= next_latch_addr;
      ma         <= next_ma;
      ma_oe      <= next_ma_oe;
      sa_out     <= next_sa_out;
      sa_oe      <= next_sa_oe;
      xa_out     <= next_xa_out;
      xa_oe      <= next_xa_oe;
    end
  end

  // Output drive
  assign MEM_ADDR_OUT               = ma;
  assign MEM_ADDR_OE_OUT            = ma_oe;
  assign REFRESH_ACTIVE_OUT         = (state == dmux_pkg::DMUX_REFRESH);
  assign REFRESH_ADDR_LSB_OUT       = cnt[0];
  assign EXPANSION_ADDR_BUS_OUT     = sa_out;
  assign EXPANSION_ADDR_BUS_OE_OUT  = sa_oe;
  assign PERIPHERAL_ADDR_BUS_OUT    = xa_out;
  assign PERIPHERAL_ADDR_BUS_OE_OUT = xa_oe;

  // Checks on the core, sampled only when enabled except c_refresh_done
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);

  a_clear_floats_mem: assert property (
    CE_IN && clr |=> !MEM_ADDR_OE_OUT && cnt == `DMUX_CNT_RESET)
    else $error("Clear did not float memory address or zero counter");
  a_start_needs_permit: assert property (
    CE_IN && state == dmux_pkg::DMUX_IDLE && !(req && permit)
      |=> state == dmux_pkg::DMUX_IDLE)
    else $error("Refresh started without request and permit");
  a_refresh_start: assert property (
    CE_IN && state == dmux_pkg::DMUX_IDLE && req && permit && !clr
      |=> REFRESH_ACTIVE_OUT && MEM_ADDR_OUT == cnt)
    else $error("Refresh did not start with counter address");
  a_count_advance: assert property (
    CE_IN && state == dmux_pkg::DMUX_REFRESH && !req && !clr
      |=> cnt == MA_W'($past(cnt) + 1'b1))
    else $error("Counter did not advance after refresh");
  a_row_address: assert property (
    CE_IN && !clr && src_sel && !col_sel && !ale &&
      state == dmux_pkg::DMUX_IDLE && !(req && permit)
      |=> MEM_ADDR_OUT == latch_addr[MA_W:1])
    else $error("System row address not presented");
  a_latch_holds: assert property (
    CE_IN && !ale |=> $stable(latch_addr))
    else $error("Latched address moved without latch enable");
  a_latch_take: assert property (
    CE_IN && ale |=> latch_addr == $past(cpu_a))
    else $error("CPU address not captured");
  a_hold_release: assert property (
    CE_IN && hold |=> !EXPANSION_ADDR_BUS_OE_OUT)
    else $error("Expansion bus driven under hold acknowledge");
  a_dma_direction: assert property (
    CE_IN && dma |=> PERIPHERAL_ADDR_BUS_OE_OUT &&
      PERIPHERAL_ADDR_BUS_OUT == $past(sa_in))
    else $error("DMA direction not set toward peripheral bus");
  a_cpu_to_buses: assert property (
    CE_IN && !hold && !dma |=> EXPANSION_ADDR_BUS_OE_OUT &&
      EXPANSION_ADDR_BUS_OUT == PERIPHERAL_ADDR_BUS_OUT)
    else $error("CPU address not driven to both buses");
  a_lsb_tracks: assert property (
    CE_IN && state == dmux_pkg::DMUX_REFRESH && !req && !clr
      |=> REFRESH_ADDR_LSB_OUT != $past(REFRESH_ADDR_LSB_OUT))
    else $error("Refresh address bit zero did not toggle");
  a_mem_driven: assert property (
    CE_IN && !clr |=> MEM_ADDR_OE_OUT)
    else $error("Memory address not driven in normal operation");

  c_refresh_done: cover property (
    state == dmux_pkg::DMUX_REFRESH ##1 state == dmux_pkg::DMUX_IDLE);
  c_column: cover property (CE_IN && src_sel && col_sel && ma_oe);
  c_dma_hold: cover property (CE_IN && hold && dma);
  c_clear: cover property (CE_IN && clr ##1 !clr);

endmodule

// ==== rtl/dmux_params.svh ====
// Constants for the DRAM address and refresh multiplexer.
// Assumes inclusion by the top module only.
//
// Behaviour
// - Drive an 8-bit multiplexed memory address toward the DRAM array.
// - Take CPU address bits 1 to 16 as the system memory address.
// - Source select picks system address or refresh counter for memory.
// - Clear input high clears counter and floats all memory address lines.
// - Refresh request starts a refresh cycle addressed by the counter.
// - A refresh cycle starts only while refresh permit is high.
// - Refresh address bit 0 appears on its own output line.
// - Two-way path between expansion and peripheral address buses.
// - Hold acknowledge stops the device driving the expansion bus.
// - DMA active sets the transceiver direction for DMA transfers.
`ifndef DMUX_PARAMS_SVH
`define DMUX_PARAMS_SVH
`define DMUX_MA_W        8
`define DMUX_SYS_W       16
`define DMUX_CNT_RESET   8'h00
`define DMUX_SYNC_STAGES 3
`define DMUX_CTL_W       8
`define DMUX_ADDR_RESET  16'h0000
`endif

// ==== rtl/dmux_pkg.sv ====
// Types for the DRAM address and refresh multiplexer.
// Assumes the params header is compiled alongside.
package dmux_pkg;
  // Refresh sequencer states
  typedef enum logic [0:0] {
    DMUX_IDLE,
    DMUX_REFRESH
  } dmux_state_t;
endpackage

// ==== testbench/dmux_far_model.sv ====
// Far side model: the other agent on the expansion bus and the wire levels of both
// address buses. Assumes the bench hands it the design's drive values.
`timescale 1ns/1ps

module dmux_far_model (
  // Clock
  input  wire logic        clk_in,
  // Other agent on the expansion bus
  input  wire logic [16:1] agent_addr_in,
  input  wire logic        agent_on_in,
  // Design drive values
  input  wire logic [16:1] exp_dev_in,
  input  wire logic        exp_oe_in,
  input  wire logic [16:1] per_dev_in,
  input  wire logic        per_oe_in,
  // Resolved wire levels
  output logic      [16:1] exp_bus_out,
  output logic      [16:1] per_bus_out
);
  logic [16:1] last_exp;
  logic [16:1] last_per;

  // Undriven lines show a changing pattern, never the last value
  always_ff @(posedge clk_in) begin
    last_exp <= exp_bus_out;
    last_per <= per_bus_out;
  end

  // Wire resolution: design first, then the agent on the expansion bus, then floating
  assign exp_bus_out = exp_oe_in ? exp_dev_in :
                       agent_on_in ? agent_addr_in : ~last_exp;
  assign per_bus_out = per_oe_in ? per_dev_in : ~last_per;
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the DRAM address and refresh multiplexer.
// Assumes a 5-edge pin-to-output latency; checks after 8 cycles.
`timescale 1ns/1ps

module tb;
  logic        clk = 0, nrst = 0, ce = 1, ale = 0, req = 0, perm = 0;
  logic        src = 1, col = 0, clr = 0, hold = 0, dma = 0, agent_on = 0;
  logic [16:1] cpu_addr = '0, agent = '0, a, exp_in, per_in;
  logic [16:1] exp_out, per_out;
  logic [7:0]  ma, cnt;
  logic        ma_oe, ract, lsb, exp_oe, per_oe;
  int          n_errors = 0, num_checks = 0, cyc = 0;

  dmux_top dmux_top_inst (.CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce),
    .CPU_ADDR_IN(cpu_addr), .ALE_IN(ale), .REFRESH_REQ_IN(req),
    .REFRESH_PERMIT_IN(perm), .ADDR_SOURCE_SELECT_IN(src),
    .COLUMN_SELECT_IN(col), .COUNTER_CLEAR_IN(clr),
    .CPU_HOLD_ACK_IN(hold), .DMA_ACTIVE_IN(dma), .MEM_ADDR_OUT(ma),
    .MEM_ADDR_OE_OUT(ma_oe), .REFRESH_ACTIVE_OUT(ract),
    .REFRESH_ADDR_LSB_OUT(lsb), .EXPANSION_ADDR_BUS_IN(exp_in),
    .EXPANSION_ADDR_BUS_OUT(exp_out), .EXPANSION_ADDR_BUS_OE_OUT(exp_oe),
    .PERIPHERAL_ADDR_BUS_IN(per_in), .PERIPHERAL_ADDR_BUS_OUT(per_out),
    .PERIPHERAL_ADDR_BUS_OE_OUT(per_oe));

  dmux_far_model dmux_far_model_inst (.clk_in(clk), .agent_addr_in(agent),
    .agent_on_in(agent_on), .exp_dev_in(exp_out), .exp_oe_in(exp_oe),
    .per_dev_in(per_out), .per_oe_in(per_oe), .exp_bus_out(exp_in),
    .per_bus_out(per_in));

  // Clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic check(input logic [16:1] seen, input logic [16:1] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Inputs move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic [16:1] row_of(input logic [16:1] v);
    return 16'(v[8:1]);
  endfunction

  function automatic logic [16:1] col_of(input logic [16:1] v);
    return 16'(v[16:9]);
  endfunction

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    void'($urandom(40));
    step(10);
    nrst = 1;
    step(2);
    // CPU address: row, column, latch hold; all-ones corner first
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 16'hFFFF : 16'($urandom);
      cpu_addr = a; ale = 1; col = 0;
      step(8);
      check(row_of(ma), row_of(a));
      check(16'(ma_oe), 16'h0001);
      check(exp_out, a);
      check(per_out, a);
      check(16'(exp_oe & per_oe), 16'h0001);
      col = 1;
      step(8);
      check(16'(ma), col_of(a));
      ale = 0; cpu_addr = ~a;
      step(8);
      check(16'(ma), col_of(a));
      // Row half of the held address after the latch closed
      col = 0;
      step(8);
      check(row_of(ma), row_of(a));
    end
    // Refresh cycles from the counter
    cnt = 8'h00; perm = 1;
    for (int i = 0; i < 3; i++) begin
      // Source select high, so the counter must override it
      src = 1; req = 1;
      step(8);
      check(16'(ract), 16'h0001);
      check(16'(ma), 16'(cnt));
      req = 0; src = 0;
      step(8);
      cnt++;
      check(16'(ma), 16'(cnt));
      check(16'(lsb), 16'(cnt[0]));
    end
    // Request refused without permit
    perm = 0; req = 1;
    step(8);
    check(16'(ract), 16'h0000);
    req = 0;
    step(8);
    check(16'(ma), 16'(cnt));
    // Clear floats the address and zeroes the counter
    clr = 1;
    step(8);
    check(16'(ma_oe), 16'h0000);
    clr = 0;
    step(8);
    check(16'({ma_oe, ma}), 16'h0100);
    // Hold releases both buses
    hold = 1;
    step(8);
    check(16'({exp_oe, per_oe}), 16'h0000);
    // DMA: agent drives expansion, device drives peripheral
    dma = 1; agent = 16'($urandom); agent_on = 1;
    step(8);
    check(16'({exp_oe, per_oe}), 16'h0001);
    check(per_out, agent);
    hold = 0; agent_on = 0;
    step(8);
    check(16'({exp_oe, per_oe}), 16'h0003);
    check(exp_out, agent);
    stop_test();
  end
endmodule
